// >>> common/isp_map.svh
// Purpose: Shared constants of the serial programming port: opcodes, erased values and wait times.
// Assumes: Included by its bare name; definitions only.
// Notes:   Times are in ns; cycle counts are derived from them in the top module.
// Operation
// - Instructions accepted only while reset pin low.
// - Chip erase fills both arrays with 0xFF.
// - Input bits sampled on serial clock rise.
// - Output bits shifted on serial clock fall.
// - Second enable byte echoes during third byte.
// - Page buffer loaded bytewise, low before high.
// - Write-page commits whole buffer to page.
// - Data byte written with automatic erase first.
// - Read returns addressed content on serial output.
// - Reset pin high leaves programming mode.
// - Page under programming reads as 0xFF.
// - Enable is AC 53, two don't-care bytes.
// - Chip erase is AC then 100 prefix.
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH

// ============================================================
// Timing
`define REF_CLK_PERIOD_NS      100
`define PROG_MEM_WRITE_WAIT_NS 4500000
`define DATA_MEM_WRITE_WAIT_NS 9000000
`define CHIP_ERASE_WAIT_NS     9000000

// ============================================================
// Instruction encodings
`define OP_ENABLE_B0      8'hAC
`define OP_ENABLE_B1      8'h53
`define OP_ERASE_B1_TOP   3'h4
`define OP_READ_PROG_TOP  4'h2
`define OP_LOAD_PAGE_TOP  4'h4
`define OP_LOW_BITS_ZERO  3'h0
`define OP_WRITE_PAGE     8'h4C
`define OP_READ_DATA      8'hA0
`define OP_WRITE_DATA     8'hC0

// ============================================================
// Values
`define ERASED_BYTE       8'hFF
`define ERASED_WORD       16'hFFFF
`define IDLE_BYTE         8'h00

`endif

// >>> common/isp_pkg.sv
// Purpose: Types of the serial programming port.
// Assumes: Nothing.
// Notes:   Enumerations are Gray coded along the usual path.
package isp_pkg;

  // ============================================================
  // Busy kinds
  typedef enum logic [1:0] {
    BUSY_IDLE  = 2'h0,
    BUSY_PAGE  = 2'h1,
    BUSY_DATA  = 2'h3,
    BUSY_ERASE = 2'h2
  } busy_e;

  // ============================================================
  // Array sweep modes
  typedef enum logic [1:0] {
    SWEEP_IDLE   = 2'h0,
    SWEEP_COMMIT = 2'h1,
    SWEEP_ERASE  = 2'h3
  } sweep_e;

endpackage

// >>> rtl/nvm_store.sv
// Purpose: Program array, data array and page buffer with commit and erase sweeps.
// Assumes: DATA_AW is not above PROG_AW.
// Notes:   Reads are combinational.
`timescale 1ns/100ps
`default_nettype none
`include "isp_map.svh"

module nvm_store
  import isp_pkg::*;
#(
  parameter int PROG_AW = 12,
  parameter int PAGE_AW = 5,
  parameter int DATA_AW = 9
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       buf_we,
  input  wire logic                       buf_hi,
  input  wire logic [PAGE_AW-1:0]         buf_word,
  input  wire logic [7:0]                 buf_byte,
  input  wire logic                       commit_start,
  input  wire logic [PROG_AW-PAGE_AW-1:0] commit_page,
  input  wire logic                       data_we,
  input  wire logic [DATA_AW-1:0]         data_addr,
  input  wire logic [7:0]                 data_byte,
  input  wire logic                       erase_start,
  input  wire logic [PROG_AW-1:0]         prog_rd_addr,
  output logic      [15:0]                prog_rd_word,
  input  wire logic [DATA_AW-1:0]         data_rd_addr,
  output logic      [7:0]                 data_rd_byte,
  output logic                            sweeping
);

  typedef struct packed {
    sweep_e                       mode;
    logic [PROG_AW-1:0]           idx;
    logic [PROG_AW-PAGE_AW-1:0]   page;
  } store_s;

  store_s      s;
  store_s      next_s;
  logic [15:0] prog_mem [0:(2**PROG_AW)-1];
  logic [7:0]  data_mem [0:(2**DATA_AW)-1];
  logic [15:0] page_buf [0:(2**PAGE_AW)-1];

  // ============================================================
  // Sweep control
  always_comb begin
    next_s = s;
    case (s.mode)
      SWEEP_IDLE: begin
        next_s.idx = '0;
        if (erase_start) begin
          next_s.mode = SWEEP_ERASE;
        end else if (commit_start) begin
          next_s.mode = SWEEP_COMMIT;
          next_s.page = commit_page;
        end
      end
      SWEEP_COMMIT: begin
        next_s.idx = s.idx + 1'b1;
        if (&s.idx[PAGE_AW-1:0]) begin
          next_s.mode = SWEEP_IDLE;
        end
      end
      SWEEP_ERASE: begin
        next_s.idx = s.idx + 1'b1;
        if (&s.idx) begin
          next_s.mode = SWEEP_IDLE;
        end
      end
      default: begin
        next_s.mode = SWEEP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // Arrays
  always_ff @(posedge ref_clk) begin
    if (buf_we) begin
      if (buf_hi) begin
        page_buf[buf_word][15:8] <= buf_byte;
      end else begin
        page_buf[buf_word][7:0] <= buf_byte;
      end
    end
    if (s.mode == SWEEP_COMMIT) begin
      prog_mem[{s.page, s.idx[PAGE_AW-1:0]}] <= page_buf[s.idx[PAGE_AW-1:0]];
    end
    if (s.mode == SWEEP_ERASE) begin
      prog_mem[s.idx] <= `ERASED_WORD;
      data_mem[s.idx[DATA_AW-1:0]] <= `ERASED_BYTE;
    end
    if (data_we) begin
      data_mem[data_addr] <= data_byte;
    end
  end

  assign prog_rd_word = prog_mem[prog_rd_addr];
  assign data_rd_byte = data_mem[data_rd_addr];
  assign sweeping     = (s.mode != SWEEP_IDLE);

endmodule
`default_nettype wire

// >>> rtl/serial_isp_programming_port.sv
// Purpose: Serial in-system programming front end reaching program and data arrays.
// Assumes: Serial clock, data and reset pin are asynchronous to ref_clk.
// Notes:   Wait times are parameters so that a simulation can shorten them.
`timescale 1ns/100ps
`default_nettype none
`include "isp_map.svh"

module serial_isp_programming_port
  import isp_pkg::*;
#(
  parameter int PROG_AW        = 12,
  parameter int PAGE_AW        = 5,
  parameter int DATA_AW        = 9,
  parameter int BUSY_W         = 17,
  parameter int PROG_WAIT_CYC  = `PROG_MEM_WRITE_WAIT_NS / `REF_CLK_PERIOD_NS,
  parameter int DATA_WAIT_CYC  = `DATA_MEM_WRITE_WAIT_NS / `REF_CLK_PERIOD_NS,
  parameter int ERASE_WAIT_CYC = `CHIP_ERASE_WAIT_NS / `REF_CLK_PERIOD_NS
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic reset_n_pin,
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  output logic      prog_mode,
  output logic      busy
);

  localparam int PG_W = PROG_AW - PAGE_AW;

  typedef struct packed {
    logic                  rst_s1;
    logic                  rst_s2;
    logic                  sck_s1;
    logic                  sck_s2;
    logic                  sck_q;
    logic                  mosi_s1;
    logic                  mosi_s2;
    logic [7:0]            shift;
    logic [2:0]            bit_cnt;
    logic [1:0]            byte_idx;
    logic [7:0]            b0;
    logic [7:0]            b1;
    logic [7:0]            b2;
    logic [7:0]            tx;
    logic                  miso;
    logic                  miso_oe;
    logic                  prog_mode;
    logic                  enabled;
    logic                  busy;
    busy_e                 busy_kind;
    logic [BUSY_W-1:0]     busy_cnt;
    logic [PG_W-1:0]       busy_page;
    logic [DATA_AW-1:0]    busy_daddr;
    logic                  buf_we;
    logic                  buf_hi;
    logic [PAGE_AW-1:0]    st_word;
    logic [7:0]            st_byte;
    logic                  commit_start;
    logic [PG_W-1:0]       st_page;
    logic                  data_we;
    logic [DATA_AW-1:0]    st_daddr;
    logic                  erase_start;
  } port_s;

  port_s              s;
  port_s              next_s;
  logic [7:0]         rx_byte;
  logic [PROG_AW-1:0] prog_rd_addr;
  logic [DATA_AW-1:0] data_rd_addr;
  logic [15:0]        prog_rd_word;
  logic [7:0]         data_rd_byte;
  logic               sweeping;
  logic               sck_rise;
  logic               sck_fall;
  logic [7:0]         rd_result;
  logic [15:0]        rd_word;
  logic [PROG_AW-1:0] wr_addr;

  // ============================================================
  // Address decoding
  function automatic logic [PROG_AW-1:0] word_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[PROG_AW-1:0];
  endfunction

  function automatic logic [DATA_AW-1:0] byte_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[DATA_AW-1:0];
  endfunction

  assign rx_byte      = {s.shift[6:0], s.mosi_s2};
  assign prog_rd_addr = word_addr(s.b1, rx_byte);
  assign data_rd_addr = byte_addr(s.b1, rx_byte);
  assign sck_rise     = s.sck_s2 & ~s.sck_q;
  assign sck_fall     = ~s.sck_s2 & s.sck_q;
  assign wr_addr      = word_addr(s.b1, s.b2);

  // ============================================================
  // Read answer
  always_comb begin
    rd_word   = prog_rd_word;
    rd_result = `IDLE_BYTE;
    if ((s.busy_kind == BUSY_PAGE) && (prog_rd_addr[PROG_AW-1:PAGE_AW] == s.busy_page)) begin
      rd_word = `ERASED_WORD;
    end
    if (s.enabled) begin
      if ((s.b0[7:4] == `OP_READ_PROG_TOP) && (s.b0[2:0] == `OP_LOW_BITS_ZERO)) begin
        rd_result = s.b0[3] ? rd_word[15:8] : rd_word[7:0];
      end else if (s.b0 == `OP_READ_DATA) begin
        if ((s.busy_kind == BUSY_DATA) && (data_rd_addr == s.busy_daddr)) begin
          rd_result = `ERASED_BYTE;
        end else begin
          rd_result = data_rd_byte;
        end
      end
    end
  end

  // ============================================================
  // Link and instruction engine
  always_comb begin
    next_s              = s;
    next_s.rst_s1       = reset_n_pin;
    next_s.rst_s2       = s.rst_s1;
    next_s.sck_s1       = sck;
    next_s.sck_s2       = s.sck_s1;
    next_s.sck_q        = s.sck_s2;
    next_s.mosi_s1      = mosi;
    next_s.mosi_s2      = s.mosi_s1;
    next_s.buf_we       = 1'b0;
    next_s.commit_start = 1'b0;
    next_s.data_we      = 1'b0;
    next_s.erase_start  = 1'b0;
    if (s.busy_cnt != '0) begin
      next_s.busy_cnt = s.busy_cnt - 1'b1;
    end else if (!sweeping) begin
      next_s.busy_kind = BUSY_IDLE;
    end
    next_s.busy = (s.busy_kind != BUSY_IDLE);
    if (s.rst_s2) begin
      next_s.prog_mode = 1'b0;
      next_s.miso_oe   = 1'b0;
      next_s.miso      = 1'b0;
      next_s.enabled   = 1'b0;
      next_s.bit_cnt   = '0;
      next_s.byte_idx  = '0;
      next_s.tx        = `IDLE_BYTE;
    end else begin
      next_s.prog_mode = 1'b1;
      next_s.miso_oe   = 1'b1;
      if (sck_fall) begin
        next_s.miso = s.tx[7];
        next_s.tx   = {s.tx[6:0], 1'b0};
      end
      if (sck_rise) begin
        next_s.shift   = rx_byte;
        next_s.bit_cnt = s.bit_cnt + 3'h1;
        if (s.bit_cnt == 3'h7) begin
          next_s.byte_idx = s.byte_idx + 2'h1;
          case (s.byte_idx)
            2'h0: begin
              next_s.b0 = rx_byte;
              next_s.tx = rx_byte;
            end
            2'h1: begin
              next_s.b1 = rx_byte;
              next_s.tx = rx_byte;
            end
            2'h2: begin
              next_s.b2 = rx_byte;
              next_s.tx = rd_result;
            end
            default: begin
              next_s.tx = `IDLE_BYTE;
              if ((s.b0 == `OP_ENABLE_B0) && (s.b1 == `OP_ENABLE_B1)) begin
                next_s.enabled = 1'b1;
              end else if (s.enabled) begin
                if ((s.b0 == `OP_ENABLE_B0) && (s.b1[7:5] == `OP_ERASE_B1_TOP)) begin
                  next_s.erase_start = 1'b1;
                  next_s.busy_kind   = BUSY_ERASE;
                  next_s.busy_cnt    = BUSY_W'(ERASE_WAIT_CYC);
                end else if ((s.b0[7:4] == `OP_LOAD_PAGE_TOP) && (s.b0[2:0] == `OP_LOW_BITS_ZERO)) begin
                  next_s.buf_we  = 1'b1;
                  next_s.buf_hi  = s.b0[3];
                  next_s.st_word = s.b2[PAGE_AW-1:0];
                  next_s.st_byte = rx_byte;
                end else if (s.b0 == `OP_WRITE_PAGE) begin
                  next_s.commit_start = 1'b1;
                  next_s.st_page      = wr_addr[PROG_AW-1:PAGE_AW];
                  next_s.busy_page    = wr_addr[PROG_AW-1:PAGE_AW];
                  next_s.busy_kind    = BUSY_PAGE;
                  next_s.busy_cnt     = BUSY_W'(PROG_WAIT_CYC);
                end else if (s.b0 == `OP_WRITE_DATA) begin
                  next_s.data_we    = 1'b1;
                  next_s.st_daddr   = byte_addr(s.b1, s.b2);
                  next_s.busy_daddr = byte_addr(s.b1, s.b2);
                  next_s.st_byte    = rx_byte;
                  next_s.busy_kind  = BUSY_DATA;
                  next_s.busy_cnt   = BUSY_W'(DATA_WAIT_CYC);
                end
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s        <= '0;
      s.rst_s1 <= 1'b1;
      s.rst_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // Arrays
  nvm_store #(
    .PROG_AW (PROG_AW),
    .PAGE_AW (PAGE_AW),
    .DATA_AW (DATA_AW)
  ) u_store (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .buf_we       (s.buf_we),
    .buf_hi       (s.buf_hi),
    .buf_word     (s.st_word),
    .buf_byte     (s.st_byte),
    .commit_start (s.commit_start),
    .commit_page  (s.st_page),
    .data_we      (s.data_we),
    .data_addr    (s.st_daddr),
    .data_byte    (s.st_byte),
    .erase_start  (s.erase_start),
    .prog_rd_addr (prog_rd_addr),
    .prog_rd_word (prog_rd_word),
    .data_rd_addr (data_rd_addr),
    .data_rd_byte (data_rd_byte),
    .sweeping     (sweeping)
  );

  assign miso      = s.miso;
  assign miso_oe   = s.miso_oe;
  assign prog_mode = s.prog_mode;
  assign busy      = s.busy;

endmodule
`default_nettype wire

// >>> tb/isp_port_props.sv
// Purpose: Concurrent checks on the serial programming port pins.
// Assumes: Bound to serial_isp_programming_port.
// Notes:   Busy bounds follow the wait parameters.
`timescale 1ns/100ps
`default_nettype none

module isp_port_props #(
  parameter int PROG_WAIT_CYC  = 45000,
  parameter int ERASE_WAIT_CYC = 90000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic prog_mode,
  input wire logic busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ============================================================
  // Busy run length
  int run;

  always_ff @(posedge ref_clk) begin
    if (rst || !busy) begin
      run <= 0;
    end else begin
      run <= run + 1;
    end
  end

  // ============================================================
  // Properties
  mode_off_a: assert property (reset_n_pin [*5] |-> !prog_mode)
    else $error("prog_mode high with reset pin high");
  oe_off_a: assert property (reset_n_pin [*5] |-> !miso_oe)
    else $error("miso_oe high with reset pin high");
  miso_off_a: assert property (reset_n_pin [*5] |-> !miso)
    else $error("miso high outside programming mode");
  mode_on_a: assert property (!reset_n_pin [*6] |-> prog_mode)
    else $error("prog_mode low with reset pin low");
  miso_hold_a: assert property ($changed(miso) && prog_mode && $past(prog_mode) |-> $past(sck, 4) && !$past(sck, 3))
    else $error("miso changed other than after an sck fall");
  busy_mode_a: assert property ($rose(busy) |-> prog_mode)
    else $error("busy rose outside programming mode");
  busy_min_a: assert property ($fell(busy) && !$past(rst) |-> run >= PROG_WAIT_CYC)
    else $error("busy shorter than write wait");
  busy_max_a: assert property (run <= ERASE_WAIT_CYC + 4200)
    else $error("busy longer than erase wait");
endmodule

bind serial_isp_programming_port isp_port_props #(
  .PROG_WAIT_CYC  (PROG_WAIT_CYC),
  .ERASE_WAIT_CYC (ERASE_WAIT_CYC)
) u_props (
  .ref_clk     (ref_clk),
  .rst         (rst),
  .reset_n_pin (reset_n_pin),
  .sck         (sck),
  .mosi        (mosi),
  .miso        (miso),
  .miso_oe     (miso_oe),
  .prog_mode   (prog_mode),
  .busy        (busy)
);

`default_nettype wire

// >>> tb/isp_programmer.sv
// Purpose: Model of the external programmer driving the serial link.
// Assumes: Link clock period 800 ns, idle low.
// Notes:   Frames are always four whole bytes.
`timescale 1ns/100ps
`default_nettype none

module isp_programmer (
  input  wire logic ref_clk,
  input  wire logic miso,
  output logic      reset_n_pin,
  output logic      sck,
  output logic      mosi
);
  initial begin
    reset_n_pin = 1'h0;
    sck = 1'h0;
    mosi = 1'h0;
  end

  // Sets the reset pin and waits n cycles.
  task automatic pin(input logic v, input int n);
    @(posedge ref_clk);
    #1 reset_n_pin = v;
    repeat (n) @(posedge ref_clk);
  endtask

  // Shifts one instruction and gathers the returned bytes.
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    @(posedge ref_clk);
    #1;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #400 sck = 1'h1;
      rx[i] = miso;
      #400 sck = 1'h0;
    end
    mosi = ~mosi;
  endtask
endmodule

`default_nettype wire

// >>> tb/tb_serial_isp_programming_port.sv
// Purpose: Self-checking bench of the serial programming port.
// Assumes: isp_programmer drives reset_n_pin, sck and mosi; miso comes from the port.
// Notes:   Wait counts and the power-up wait are shortened.
`timescale 1ns/100ps
`default_nettype none

module tb_serial_isp_programming_port;
  localparam int PW = 600;
  localparam int EW = 5000;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic        reset_n_pin, sck, mosi, miso, miso_oe, prog_mode, busy;
  int          fails = 0;
  int          cmp_count = 0;
  logic [31:0] rx;
  logic [7:0]  pb [8];
  logic [7:0]  v;
  logic [8:0]  a;
  logic [6:0]  pg;

  always #50 ref_clk = ~ref_clk;

  serial_isp_programming_port #(.PROG_WAIT_CYC(PW), .DATA_WAIT_CYC(PW + 100), .ERASE_WAIT_CYC(EW)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .reset_n_pin(reset_n_pin), .sck(sck), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .prog_mode(prog_mode), .busy(busy));
  isp_programmer u_prog (.ref_clk(ref_clk), .miso(miso), .reset_n_pin(reset_n_pin), .sck(sck), .mosi(mosi));

  function automatic logic [31:0] f_rdp(input logic [11:0] w, input logic h);
    return {4'h2, h, 3'h0, 4'h0, w, 8'h00};
  endfunction
  function automatic logic [31:0] f_ld(input logic [4:0] w, input logic h, input logic [7:0] b);
    return {4'h4, h, 3'h0, 8'h00, 3'h0, w, b};
  endfunction
  function automatic logic [31:0] f_dat(input logic [7:0] op, input logic [8:0] ad, input logic [7:0] b);
    return {op, 7'h00, ad, b};
  endfunction

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic op(input logic [31:0] tx);
    u_prog.frame(tx, rx);
    check(rx[31:24], 8'h00);
    check(rx[23:16], tx[31:24]);
    check(rx[15:8], tx[23:16]);
  endtask

  task automatic idle();
    repeat (8) @(posedge ref_clk);
    for (int n = 0; n < 20000 && busy !== 1'h0; n++) begin
      @(posedge ref_clk);
    end
    check(busy, 1'h0);
  endtask

  initial begin
    #(100 * 60000);
    fails++;
    results();
  end

  initial begin
    void'($urandom(83448));
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'h0;
    u_prog.pin(1'h1, 8);
    u_prog.pin(1'h0, 2000);
    op(f_dat(8'hA0, 9'h000, 8'h00));
    check(rx[7:0], 8'h00);
    op({8'hAC, 8'h53, 16'($urandom)});
    check(prog_mode, 1'h1);
    check(miso_oe, 1'h1);
    $display("test enable done");
    op({8'hAC, 3'h4, 5'($urandom), 16'($urandom)});
    idle();
    for (int i = 0; i < 4; i++) begin
      a = 9'($urandom);
      op(f_rdp(12'($urandom), i[0]));
      check(rx[7:0], 8'hFF);
      op(f_dat(8'hA0, a, 8'h00));
      check(rx[7:0], 8'hFF);
    end
    $display("test erase done");
    pg = 7'($urandom);
    for (int i = 0; i < 8; i++) begin
      pb[i] = 8'($urandom);
      op(f_ld(5'(i / 2), i[0], pb[i]));
    end
    op({8'h4C, 4'h0, pg[6:3], pg[2:0], 5'h00, 8'h00});
    op(f_rdp({pg, 5'h03}, 1'h0));
    check(rx[7:0], 8'hFF);
    idle();
    for (int i = 0; i < 8; i++) begin
      op(f_rdp({pg, 5'(i / 2)}, i[0]));
      check(rx[7:0], pb[i]);
    end
    $display("test page done");
    a = 9'($urandom);
    v = 8'($urandom);
    op(f_dat(8'hC0, a, v));
    op(f_dat(8'hA0, a, 8'h00));
    check(rx[7:0], 8'hFF);
    idle();
    op(f_dat(8'hA0, a, 8'h00));
    check(rx[7:0], v);
    $display("test data done");
    u_prog.pin(1'h1, 8);
    check(prog_mode, 1'h0);
    check(miso_oe, 1'h0);
    u_prog.pin(1'h0, 2000);
    op(f_dat(8'hC0, a, ~v));
    repeat (8) @(posedge ref_clk);
    check(busy, 1'h0);
    op({8'hAC, 8'h53, 16'h0000});
    op(f_dat(8'hA0, a, 8'h00));
    check(rx[7:0], v);
    $display("test leave done");
    results();
  end
endmodule

`default_nettype wire
